// ---- hw/aish_top.sv ----
// Axis input, stop and encoder handling for one axis
// Notes on behaviour
// - Each isolated input is filtered, default 512 us, adjustable or bypassed.
// - Enabled Z-phase input halts drive pulses when it goes active.
// - Mode one bits 5,4 enable Z-phase stop and select its level.
// - Z-phase level select resets to zero.
// - Home search stops on inactive-to-active Z edge only.
// - With settle input enabled, busy holds until settle input active.
// - Mode two bits 15,14 enable settle input and select its level.
// - Enabled active fault input sets alarm status and stops at once.
// - Mode two bits 13,12 enable fault input and select its level.
// - Settle and fault functions are disabled after reset.
// - Filtered input levels are always readable as input status.
// - Encoder A/B quadrature counts the real position up or down.
// - Differential pair high/low gives low, low/high gives high.
// - Encoder path adds under 100 ns and counts 4 MHz quadrature.
// - Fixed mode: falling edge on plus/minus starts preset move.
// - Continuous mode: pulses run while plus or minus input is low.
// - Emergency stop halts all drive at once and sets error bit.
// - Emergency stop level is jumper selected; short to ground default.
`timescale 1ns/100ps
module aish_top
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [15:0] mode_reg_one,
  input wire logic [15:0] mode_reg_two,
  input wire logic filter_bypass,
  input wire logic [aish_pkg::FILT_W-1:0] filter_delay,
  input wire logic filter_delay_load,
  input wire logic zphase_stop_input,
  input wire logic servo_settled_input,
  input wire logic servo_fault_input,
  input wire logic ext_drive_plus_input,
  input wire logic ext_drive_minus_input,
  input wire logic emergency_stop_input,
  input wire logic estop_level_jumper,
  input wire logic encoder_phase_a_pos,
  input wire logic encoder_phase_a_neg,
  input wire logic encoder_phase_b_pos,
  input wire logic encoder_phase_b_neg,
  input wire logic ext_drive_enable,
  input wire logic ext_fixed_mode,
  input wire logic home_search,
  input wire logic sw_drive_start,
  input wire logic pulse_done,
  input wire logic error_clear,
  input wire logic alarm_clear,
  output logic drive_run,
  output logic drive_dir_minus,
  output logic drive_fixed,
  output logic axis_drive_busy_flag,
  output logic axis_error_flag,
  output logic axis_alarm_flag,
  output logic zphase_stop_seen,
  output logic [aish_pkg::NUM_FILT-1:0] input_status_one,
  output logic [aish_pkg::POS_W-1:0] real_position
);
  // Two-flop synchronisers for all external pins except the estop level jumper
  localparam int NSYNC = aish_pkg::NUM_FILT + 2;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [aish_pkg::FILT_W-1:0] delay_reg;
  logic bypass_reg;
  logic [aish_pkg::NUM_FILT-1:0] filt_level;
  logic enc_a;
  logic enc_b;

  // Positive low / negative high reads as high
  assign enc_a = ~encoder_phase_a_pos & encoder_phase_a_neg;
  assign enc_b = ~encoder_phase_b_pos & encoder_phase_b_neg;

  assign pin_raw = {enc_b, enc_a, emergency_stop_input,
    ext_drive_minus_input, ext_drive_plus_input, servo_fault_input,
    servo_settled_input, zphase_stop_input};

  // No reset here: true pin levels on release avoid a false encoder count
  always_ff @(posedge clk_sys)
  begin
    sync1_reg <= pin_raw;
    sync2_reg <= sync1_reg;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      delay_reg <= aish_pkg::FILT_DEFAULT;
      bypass_reg <= 1'b0;
    end
    else
    begin
      bypass_reg <= filter_bypass;
      if (filter_delay_load)
        delay_reg <= filter_delay;
    end
  end

  // One filter per isolated input; encoder bypasses filtering for speed
  genvar gi;
  generate
    for (gi = 0; gi < aish_pkg::NUM_FILT; gi++)
    begin : g_filt
      aish_filt_if fif ();
      assign fif.bypass = bypass_reg;
      assign fif.delay = delay_reg;
      assign fif.raw = sync2_reg[gi];
      assign filt_level[gi] = fif.level;
      aish_filter u_filt
      (
        .clk_sys(clk_sys),
        .reset(reset),
        .fi(fif)
      );
    end
  endgenerate

  // Active-level decode; level select 0 means low active
  logic zph_act;
  logic settle_act;
  logic fault_act;
  logic estop_act;
  logic zph_prev_reg;
  logic zph_rise;
  logic zph_stop;
  logic fault_stop;
  assign zph_act = filt_level[aish_pkg::IS_ZPH] ^
    ~mode_reg_one[aish_pkg::M1_ZPH_LVL];
  assign settle_act = filt_level[aish_pkg::IS_SETTLE] ^
    ~mode_reg_two[aish_pkg::M2_SETTLE_LVL];
  assign fault_act = filt_level[aish_pkg::IS_FAULT] ^
    ~mode_reg_two[aish_pkg::M2_FAULT_LVL];
  // Jumper low: shorted to ground is active; high: open input is active
  assign estop_act = estop_level_jumper ?
    filt_level[aish_pkg::IS_ESTOP] : ~filt_level[aish_pkg::IS_ESTOP];
  assign zph_rise = zph_act & ~zph_prev_reg;
  assign zph_stop = mode_reg_one[aish_pkg::M1_ZPH_EN] &
    (home_search ? zph_rise : zph_act);
  assign fault_stop = mode_reg_two[aish_pkg::M2_FAULT_EN] & fault_act;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      zph_prev_reg <= 1'b1;
    else
      zph_prev_reg <= zph_act;
  end

  // External drive edge detection
  logic plus_prev_reg;
  logic minus_prev_reg;
  logic plus_fall;
  logic minus_fall;
  logic plus_low;
  logic minus_low;
  assign plus_low = ~filt_level[aish_pkg::IS_PLUS];
  assign minus_low = ~filt_level[aish_pkg::IS_MINUS];
  assign plus_fall = plus_low & ~plus_prev_reg;
  assign minus_fall = minus_low & ~minus_prev_reg;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      plus_prev_reg <= 1'b0;
      minus_prev_reg <= 1'b0;
    end
    else
    begin
      plus_prev_reg <= plus_low;
      minus_prev_reg <= minus_low;
    end
  end

  // Drive sequencer
  aish_pkg::aish_state_t state_reg;
  aish_pkg::aish_state_t state_next;
  logic hard_stop;
  logic cont_hold;
  assign hard_stop = estop_act | fault_stop | zph_stop;
  assign cont_hold = ~drive_fixed &
    (drive_dir_minus ? minus_low : plus_low);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      aish_pkg::AISH_IDLE:
        if (!hard_stop && (sw_drive_start || (ext_drive_enable &&
          (ext_fixed_mode ? (plus_fall || minus_fall)
          : (plus_low || minus_low)))))
          state_next = aish_pkg::AISH_DRIVE;
      aish_pkg::AISH_DRIVE:
        if (hard_stop ||
          (drive_fixed ? pulse_done : !cont_hold))
          state_next = mode_reg_two[aish_pkg::M2_SETTLE_EN] ?
            aish_pkg::AISH_SETTLE : aish_pkg::AISH_IDLE;
      aish_pkg::AISH_SETTLE:
        if (!mode_reg_two[aish_pkg::M2_SETTLE_EN] || settle_act)
          state_next = aish_pkg::AISH_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      state_reg <= aish_pkg::AISH_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      drive_fixed <= 1'b1;
      drive_dir_minus <= 1'b0;
    end
    else if (state_reg == aish_pkg::AISH_IDLE &&
      state_next == aish_pkg::AISH_DRIVE)
    begin
      // Software start is always a preset move in the plus direction
      drive_fixed <= sw_drive_start | ext_fixed_mode;
      drive_dir_minus <= !sw_drive_start &&
        (ext_fixed_mode ? (minus_fall && !plus_fall)
        : (minus_low && !plus_low));
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      drive_run <= 1'b0;
      axis_drive_busy_flag <= 1'b0;
    end
    else
    begin
      drive_run <= state_next == aish_pkg::AISH_DRIVE;
      axis_drive_busy_flag <= state_next != aish_pkg::AISH_IDLE;
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      axis_error_flag <= 1'b0;
      axis_alarm_flag <= 1'b0;
      zphase_stop_seen <= 1'b0;
    end
    else
    begin
      if (estop_act)
        axis_error_flag <= 1'b1;
      else if (error_clear)
        axis_error_flag <= 1'b0;
      if (fault_stop)
        axis_alarm_flag <= 1'b1;
      else if (alarm_clear)
        axis_alarm_flag <= 1'b0;
      if (zph_stop && state_reg == aish_pkg::AISH_DRIVE)
        zphase_stop_seen <= 1'b1;
      else if (error_clear)
        zphase_stop_seen <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      input_status_one <= '1;
    else
      input_status_one <= filt_level;
  end

  // Quadrature decoder: 20 ns sampling comfortably covers 4 MHz edges
  logic [1:0] ab_prev_reg;
  logic [1:0] ab_now;
  assign ab_now = {sync2_reg[aish_pkg::NUM_FILT + 1],
    sync2_reg[aish_pkg::NUM_FILT]};

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ab_prev_reg <= ab_now;
      real_position <= '0;
    end
    else
    begin
      ab_prev_reg <= ab_now;
      // Count up when A leads B
      if ((ab_prev_reg[0] ^ ab_now[1]) && !(ab_prev_reg[1] ^ ab_now[0]))
        real_position <= real_position - 1'b1;
      else if ((ab_prev_reg[1] ^ ab_now[0]) &&
        !(ab_prev_reg[0] ^ ab_now[1]))
        real_position <= real_position + 1'b1;
    end
  end
endmodule

// ---- hw/aish_pkg.sv ----
// Shared constants and types for the axis input and stop handling block
package aish_pkg;
  localparam int CLK_MHZ = 50;
  localparam int NUM_AXES = 4;
  localparam int FILT_DEFAULT_US = 512;
  localparam int FILT_DEFAULT_CYC = FILT_DEFAULT_US * CLK_MHZ;
  localparam int FILT_W = 16;
  localparam logic [FILT_W-1:0] FILT_DEFAULT =
    FILT_DEFAULT_CYC[FILT_W-1:0];
  localparam int POS_W = 32;
  // Mode register one field positions
  localparam int M1_ZPH_EN = 5;
  localparam int M1_ZPH_LVL = 4;
  // Mode register two field positions
  localparam int M2_SETTLE_EN = 15;
  localparam int M2_SETTLE_LVL = 14;
  localparam int M2_FAULT_EN = 13;
  localparam int M2_FAULT_LVL = 12;
  localparam logic [15:0] MODE1_RESET = 16'h0000;
  localparam logic [15:0] MODE2_RESET = 16'h0000;
  // Input status bit positions
  localparam int IS_ZPH = 0;
  localparam int IS_SETTLE = 1;
  localparam int IS_FAULT = 2;
  localparam int IS_PLUS = 3;
  localparam int IS_MINUS = 4;
  localparam int IS_ESTOP = 5;
  localparam int NUM_FILT = 6;
  typedef enum logic [1:0] {AISH_IDLE, AISH_DRIVE, AISH_SETTLE} aish_state_t;
endpackage

// ---- hw/aish_filt_if.sv ----
// Interface carrying filter settings and filtered levels
`timescale 1ns/100ps
interface aish_filt_if;
  logic bypass;
  logic [aish_pkg::FILT_W-1:0] delay;
  logic raw;
  logic level;
  modport filt (input bypass, input delay, input raw, output level);
  modport user (output bypass, output delay, output raw, input level);
endinterface

// ---- hw/aish_filter.sv ----
// Noise filter: level follows input after it holds steady for delay plus one cycles
`timescale 1ns/100ps
module aish_filter
(
  input wire logic clk_sys,
  input wire logic reset,
  aish_filt_if.filt fi
);
  logic [aish_pkg::FILT_W-1:0] cnt_reg;
  logic level_reg;

  assign fi.level = level_reg;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cnt_reg <= '0;
      level_reg <= 1'b1;
    end
    else if (fi.bypass || fi.raw == level_reg)
    begin
      cnt_reg <= '0;
      level_reg <= fi.raw;
    end
    else if (cnt_reg >= fi.delay)
    begin
      cnt_reg <= '0;
      level_reg <= fi.raw;
    end
    else
      cnt_reg <= cnt_reg + 1'b1;
  end
endmodule

// ---- testbench/aish_props.sv ----
// Port-level checker for the axis input and stop block
`timescale 1ns/100ps
module aish_props
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [15:0] mode_reg_one,
  input wire logic [15:0] mode_reg_two,
  input wire logic estop_level_jumper,
  input wire logic sw_drive_start,
  input wire logic pulse_done,
  input wire logic error_clear,
  input wire logic alarm_clear,
  input wire logic drive_run,
  input wire logic drive_fixed,
  input wire logic axis_drive_busy_flag,
  input wire logic axis_error_flag,
  input wire logic axis_alarm_flag,
  input wire logic [aish_pkg::NUM_FILT-1:0] input_status_one,
  input wire logic [aish_pkg::POS_W-1:0] real_position
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence s_fault_on;
    mode_reg_two[13] && input_status_one[2] == mode_reg_two[12];
  endsequence
  // Start with every stop cause provably quiet, so it must be taken
  sequence s_start_ok;
    sw_drive_start && !axis_drive_busy_flag && &input_status_one &&
      !estop_level_jumper && !mode_reg_two[12] && !mode_reg_one[4];
  endsequence
  sequence s_settle_wait;
    mode_reg_two[15] && axis_drive_busy_flag && !drive_run &&
      !axis_error_flag;
  endsequence
  chk_fault_alarm: assert property (s_fault_on |=> axis_alarm_flag)
    else $error("fault input did not raise alarm");
  chk_fault_halt: assert property (s_fault_on |=> !drive_run)
    else $error("fault input did not stop drive");
  chk_estop_halt: assert property (
    input_status_one[5] == estop_level_jumper |=>
      axis_error_flag && !drive_run)
    else $error("emergency stop not honoured");
  chk_alarm_hold: assert property (
    axis_alarm_flag && !alarm_clear |=> axis_alarm_flag)
    else $error("alarm flag dropped without clear");
  chk_error_hold: assert property (
    axis_error_flag && !error_clear |=> axis_error_flag)
    else $error("error flag dropped without clear");
  chk_start_answer: assert property (s_start_ok |=>
    drive_run && axis_drive_busy_flag && drive_fixed)
    else $error("preset start not answered");
  chk_done_release: assert property (
    drive_run && drive_fixed && pulse_done && !mode_reg_two[15] |=>
      !drive_run && !axis_drive_busy_flag)
    else $error("busy held after finished move");
  // Busy drops on the same edge that the status shows the settle level
  chk_settle_wait: assert property (
    s_settle_wait ##0 input_status_one[1] != mode_reg_two[14] |=>
      axis_drive_busy_flag || input_status_one[1] == mode_reg_two[14])
    else $error("busy cleared before settle input");
  chk_settle_free: assert property (
    s_settle_wait ##0 input_status_one[1] != mode_reg_two[14] |=>
      !axis_drive_busy_flag || input_status_one[1] != mode_reg_two[14])
    else $error("busy held after settle input");
  chk_count_step: assert property ($changed(real_position) |->
    (real_position - $past(real_position)) inside {32'h1, 32'hFFFFFFFF})
    else $error("position moved by more than one count");
  chk_reset_state: assert property (disable iff (1'b0) reset |=>
    !drive_run && !axis_drive_busy_flag && !axis_alarm_flag &&
      !axis_error_flag && &input_status_one && real_position == 32'h0)
    else $error("reset state wrong");
endmodule
bind aish_top aish_props chk_i (.clk_sys(clk_sys), .reset(reset),
  .mode_reg_one(mode_reg_one), .mode_reg_two(mode_reg_two),
  .estop_level_jumper(estop_level_jumper), .pulse_done(pulse_done),
  .sw_drive_start(sw_drive_start), .error_clear(error_clear),
  .alarm_clear(alarm_clear), .drive_run(drive_run),
  .drive_fixed(drive_fixed), .axis_drive_busy_flag(axis_drive_busy_flag),
  .axis_error_flag(axis_error_flag), .axis_alarm_flag(axis_alarm_flag),
  .input_status_one(input_status_one), .real_position(real_position));

// ---- testbench/aish_servo_model.sv ----
// Servo driver and encoder model facing the axis input pins
`timescale 1ns/100ps
module aish_servo_model
#(
  parameter int SETTLE_LAG = 20
)
(
  input wire logic clk_sys,
  input wire logic step,
  input wire logic step_down,
  input wire logic settle_req,
  input wire logic fault_req,
  output logic a_pos,
  output logic a_neg,
  output logic b_pos,
  output logic b_neg,
  output logic settled_n,
  output logic fault_n
);
  logic [1:0] quad_reg = 2'h0;
  int lag_reg = 0;
  // Phases as {A,B}: 00 10 11 01 counting up, A leads
  always_ff @(posedge clk_sys)
  begin
    if (step)
      quad_reg <= step_down ? {quad_reg[0], ~quad_reg[1]} :
        {~quad_reg[0], quad_reg[1]};
  end
  // Slow settle answer; open collector outputs float high when off
  always_ff @(posedge clk_sys)
    lag_reg <= settle_req ? lag_reg + 1 : 0;
  assign settled_n = !(settle_req && lag_reg >= SETTLE_LAG);
  assign fault_n = !fault_req;
  assign a_pos = !quad_reg[1];
  assign a_neg = quad_reg[1];
  assign b_pos = !quad_reg[0];
  assign b_neg = quad_reg[0];
endmodule

// ---- testbench/aish_top_tb_top.sv ----
// Self-checking bench for the axis input and stop block
`timescale 1ns/100ps
module aish_top_tb_top;
  logic clk_sys = 0;
  logic reset = 1;
  logic [15:0] m1 = 0, m2 = 0;
  logic [15:0] dly = 16'h0004;
  logic byp = 0, ld = 0, home = 0, start = 0, done = 0, eclr = 0;
  logic aclr = 0, jmp = 0, z = 1, ep = 1, em = 1, es = 1, xen = 0;
  logic xfix = 1, stp = 0, sdn = 0, sreq = 0, freq = 0;
  logic a_p, a_n, b_p, b_n, settle_n, fault_n;
  logic run, dirm, fixd, busy, err, alm, zseen;
  logic [aish_pkg::NUM_FILT-1:0] st;
  logic [aish_pkg::POS_W-1:0] pos;
  int num_errors = 0, checks_done = 0, n, k;
  always #10 clk_sys = ~clk_sys;
  aish_top dut (.clk_sys(clk_sys), .reset(reset), .mode_reg_one(m1),
    .mode_reg_two(m2), .filter_bypass(byp), .filter_delay(dly),
    .filter_delay_load(ld), .zphase_stop_input(z),
    .servo_settled_input(settle_n), .servo_fault_input(fault_n),
    .ext_drive_plus_input(ep), .ext_drive_minus_input(em),
    .emergency_stop_input(es), .estop_level_jumper(jmp),
    .encoder_phase_a_pos(a_p), .encoder_phase_a_neg(a_n),
    .encoder_phase_b_pos(b_p), .encoder_phase_b_neg(b_n),
    .ext_drive_enable(xen), .ext_fixed_mode(xfix), .home_search(home),
    .sw_drive_start(start), .pulse_done(done), .error_clear(eclr),
    .alarm_clear(aclr), .drive_run(run), .drive_dir_minus(dirm),
    .drive_fixed(fixd), .axis_drive_busy_flag(busy),
    .axis_error_flag(err), .axis_alarm_flag(alm),
    .zphase_stop_seen(zseen), .input_status_one(st), .real_position(pos));
  aish_servo_model #(.SETTLE_LAG(20)) drv (.clk_sys(clk_sys), .step(stp),
    .step_down(sdn), .settle_req(sreq), .fault_req(freq), .a_pos(a_p),
    .a_neg(a_n), .b_pos(b_p), .b_neg(b_n), .settled_n(settle_n),
    .fault_n(fault_n));
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic cyc(int c);
    repeat (c) @(negedge clk_sys);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #(20 * 20000);
    num_errors++;
    close_out();
  end
  initial
  begin
    void'($urandom(39087));
    cyc(10);
    reset = 0;
    cyc(1);
    chk("reset", {6'h3F, 1'h1}, {st, fixd});
    chk("reset position", 0, pos);
    chk("flags", 0, {run, busy, err, alm, zseen});
    pulse(ld);
    ep = 0;
    cyc(4);
    chk("filter early", 1, st[3]);
    cyc(6);
    chk("filter late", 0, st[3]);
    ep = 1;
    cyc(12);
    em = 0;
    cyc(2);
    em = 1;
    cyc(10);
    chk("glitch", 1, st[4]);
    byp = 1;
    $display("filter test done");
    for (k = 0; k < 2; k++)
    begin
      m2 = k ? 16'h8000 : 16'h0000;
      cyc(4);
      pulse(start);
      chk("start", 3'h7, {run, busy, fixd});
      cyc($urandom_range(1, 20));
      pulse(done);
      chk("busy", k, busy);
      sreq = 1;
      cyc(30);
      chk("settled", 0, busy);
      sreq = 0;
    end
    m2 = 0;
    m1 = 16'h0020;
    cyc(4);
    pulse(start);
    z = 0;
    cyc(6);
    chk("z stop", 2'h1, {run, zseen});
    home = 1;
    pulse(eclr);
    pulse(start);
    cyc(6);
    chk("z held", 1, run);
    z = 1;
    cyc(6);
    z = 0;
    cyc(6);
    chk("z edge", 0, run);
    home = 0;
    z = 1;
    m1 = 0;
    $display("settle and z tests done");
    for (k = 0; k < 2; k++)
    begin
      m2 = k ? 16'h2000 : 16'h0000;
      cyc(4);
      pulse(start);
      freq = 1;
      cyc(6);
      chk("fault", k ? 2'h1 : 2'h2, {run, alm});
      chk("raw fault", 0, st[2]);
      freq = 0;
      cyc(6);
      chk("alarm hold", k, alm);
      pulse(done);
      pulse(aclr);
      chk("alarm clear", 0, alm);
    end
    for (k = 0; k < 2; k++)
    begin
      jmp = k;
      es = !k;
      cyc(6);
      pulse(eclr);
      pulse(start);
      es = k;
      cyc(6);
      chk("estop", 2'h1, {run, err});
      es = !k;
      cyc(6);
      chk("error hold", 1, err);
      pulse(eclr);
      chk("error clear", 0, err);
    end
    xen = 1;
    ep = 0;
    cyc(6);
    ep = 1;
    cyc(6);
    chk("ext fixed", 3'h6, {run, fixd, dirm});
    pulse(done);
    xfix = 0;
    em = 0;
    cyc(6);
    chk("jog", 3'h5, {run, fixd, dirm});
    em = 1;
    cyc(6);
    chk("jog end", 0, run);
    xen = 0;
    $display("fault, stop and external tests done");
    n = $urandom_range(5, 40);
    k = $urandom_range(0, 60);
    for (int i = 0; i < n + k; i++)
    begin
      sdn = (i >= n);
      pulse(stp);
      cyc(3);
    end
    cyc(6);
    chk("position", n - k, pos);
    reset = 1;
    cyc(2);
    reset = 0;
    cyc(1);
    chk("position reset", 0, pos);
    cyc(4);
    chk("position after reset", 0, pos);
    $display("encoder test done");
    close_out();
  end
endmodule
